// File: logic/fmc_consts.vh
// constants for the flash mode control register block
`ifndef FMC_CONSTS_VH
`define FMC_CONSTS_VH

// register bus address width in bits
`define FMC_ADDR_W 4
// byte offsets of the two control registers
`define FMC_OFS_LOWER 4'h0
`define FMC_OFS_UPPER 4'h4

// bit positions in flash_control_lower
`define FMC_BIT_HW_PERMIT 7
`define FMC_BIT_SW_PERMIT 6
// bit position of flash_fault_flag in flash_control_upper
`define FMC_BIT_FAULT 7
// reserved bit of flash_control_upper
`define FMC_BIT_RSVD 6

// mode field positions, shared by both halves
`define FMC_BIT_ERASE_SETUP 5
`define FMC_BIT_PROG_SETUP 4
`define FMC_BIT_ERASE_VERIFY 3
`define FMC_BIT_PROG_VERIFY 2
`define FMC_BIT_ERASE_GO 1
`define FMC_BIT_PROG_GO 0
// width of a mode field
`define FMC_MODE_W 6

// reset value of a mode field
`define FMC_MODE_RST 6'h00
// read values while the on-chip flash is disabled
`define FMC_LOWER_DISABLED 8'h80
`define FMC_UPPER_DISABLED 8'h00

// axi4-lite response codes
`define FMC_RESP_OKAY 2'b00
`define FMC_RESP_SLVERR 2'b10

`endif

// File: logic/fmc_half.v
// mode bit field for one half of the flash array
`timescale 1ns/1ps

`include "fmc_consts.vh"

module fmc_half (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_clear,
   input wire i_wr_en,
   input wire [5:0] i_wr_data,
   input wire i_permit,
   input wire i_fault,
   output reg [5:0] o_bits
);

   // next value of the mode field
   reg [5:0] next_bits;

   // gated write of the mode field, clears take priority
   always @* begin
      next_bits = o_bits;
      // setup and verify bits need both permits
      if (i_wr_en && i_permit) begin
         next_bits[`FMC_BIT_ERASE_SETUP] = i_wr_data[`FMC_BIT_ERASE_SETUP];
         next_bits[`FMC_BIT_PROG_SETUP] = i_wr_data[`FMC_BIT_PROG_SETUP];
         next_bits[`FMC_BIT_ERASE_VERIFY] = i_wr_data[`FMC_BIT_ERASE_VERIFY];
         next_bits[`FMC_BIT_PROG_VERIFY] = i_wr_data[`FMC_BIT_PROG_VERIFY];
         // erase go only after erase setup already stands
         if (o_bits[`FMC_BIT_ERASE_SETUP] && !i_fault) begin
            next_bits[`FMC_BIT_ERASE_GO] = i_wr_data[`FMC_BIT_ERASE_GO];
         end
         // program go only after program setup already stands
         if (o_bits[`FMC_BIT_PROG_SETUP] && !i_fault) begin
            next_bits[`FMC_BIT_PROG_GO] = i_wr_data[`FMC_BIT_PROG_GO];
         end
      end
      // a fault stops any erase or program in progress
      if (i_fault) begin
         next_bits[`FMC_BIT_ERASE_GO] = 1'b0;
         next_bits[`FMC_BIT_PROG_GO] = 1'b0;
      end
      // standby, or for the upper half lost permission, empties the field
      if (i_clear) begin
         next_bits = `FMC_MODE_RST;
      end
   end

   // mode field storage
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_bits <= `FMC_MODE_RST;
      end else begin
         o_bits <= next_bits;
      end
   end

endmodule

// File: logic/fmc_top.v
// flash mode control registers with an axi4-lite slave
//
// Overview of operation
// - lower verify: permit, then verify bit
// - lower program: permit, setup, then go
// - lower erase: permit, setup, then go
// - lower register reset; permit bit follows pin
// - flash disabled: lower reads 0x80, no writes
// - lower setup/verify writes need both permits
// - lower erase go needs erase setup
// - lower program go needs program setup
// - bit 7 reads inverse of protect pin
// - upper verify: permit, then verify bit
// - upper program: permit, setup, then go
// - upper erase: permit, setup, then go
// - upper clears on standby or lost permit
// - flash disabled: upper reads 0x00, no writes
// - upper setup/verify writes need both permits
// - upper erase go needs erase setup
// - upper program go needs program setup
// - fault flag sets and blocks program/erase
// - upper bit 6 always reads zero
`timescale 1ns/1ps

`include "fmc_consts.vh"

module fmc_top (
   input wire i_clk,
   input wire i_rst_n,
   // axi4-lite write address channel
   input wire [3:0] i_s_axi_awaddr,
   input wire i_s_axi_awvalid,
   output reg o_s_axi_awready,
   // axi4-lite write data channel
   input wire [31:0] i_s_axi_wdata,
   input wire [3:0] i_s_axi_wstrb,
   input wire i_s_axi_wvalid,
   output reg o_s_axi_wready,
   // axi4-lite write response channel
   output reg [1:0] o_s_axi_bresp,
   output reg o_s_axi_bvalid,
   input wire i_s_axi_bready,
   // axi4-lite read address channel
   input wire [3:0] i_s_axi_araddr,
   input wire i_s_axi_arvalid,
   output reg o_s_axi_arready,
   // axi4-lite read data channel
   output reg [31:0] o_s_axi_rdata,
   output reg [1:0] o_s_axi_rresp,
   output reg o_s_axi_rvalid,
   input wire i_s_axi_rready,
   // protect pin, high means hardware protect
   input wire i_protect_pin,
   // standby entry, clears the mode bits
   input wire i_standby,
   // high while the on-chip flash is enabled
   input wire i_flash_enabled,
   // fault report from the protection logic
   input wire i_fault_detect,
   // hardware permit, inverse of the pin
   output reg o_hardware_permit_status,
   // software write permit bit
   output reg o_software_write_permit,
   // sticky fault flag
   output reg o_flash_fault_flag,
   // lower half mode field, bits 5..0
   output wire [5:0] o_mode_lower,
   // upper half mode field, bits 5..0
   output wire [5:0] o_mode_upper
);

   // decode a byte address into {upper hit, lower hit}
   function [1:0] fmc_decode;
      input [3:0] addr;
      begin
         fmc_decode[0] = (addr[3:2] == `FMC_OFS_LOWER >> 2);
         fmc_decode[1] = (addr[3:2] == `FMC_OFS_UPPER >> 2);
      end
   endfunction

   // ------------------------------------------------------------
   // write side of the bus slave
   // ------------------------------------------------------------

   // write address has been taken and is held
   reg aw_full;
   // held write address
   reg [3:0] aw_addr;
   // write data has been taken and is held
   reg w_full;
   // held low data byte
   reg [7:0] w_byte;
   // low byte lane was enabled in the held data
   reg w_lane0;
   // both halves held, the write lands at this edge
   wire wr_commit;
   // decoded target of the held write address
   wire [1:0] wr_hit;

   assign wr_commit = aw_full && w_full && !o_s_axi_bvalid;
   assign wr_hit = fmc_decode(aw_addr);

   // address and data taken in either order, answered once both held
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aw_full <= 1'b0;
         aw_addr <= 4'h0;
         w_full <= 1'b0;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         o_s_axi_awready <= 1'b1;
         o_s_axi_wready <= 1'b1;
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp <= `FMC_RESP_OKAY;
      end else begin
         // take the write address
         if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= i_s_axi_awaddr;
            o_s_axi_awready <= 1'b0;
         end
         // take the write data, only the low lane matters
         if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_full <= 1'b1;
            w_byte <= i_s_axi_wdata[7:0];
            w_lane0 <= i_s_axi_wstrb[0];
            o_s_axi_wready <= 1'b0;
         end
         // both held: register write happens now, raise the answer
         if (wr_commit) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            // unmapped addresses answer with slave error
            if (wr_hit != 2'b00) begin
               o_s_axi_bresp <= `FMC_RESP_OKAY;
            end else begin
               o_s_axi_bresp <= `FMC_RESP_SLVERR;
            end
         end
         // answer taken, reopen both channels
         if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // register write strobes
   // ------------------------------------------------------------

   // a disabled flash ignores every register write
   wire wr_ok;
   // write aimed at the lower register
   wire wr_lower;
   // write aimed at the upper register
   wire wr_upper;
   // both permits stand
   wire both_permit;

   assign wr_ok = wr_commit && w_lane0 && i_flash_enabled;
   assign wr_lower = wr_ok && wr_hit[0];
   assign wr_upper = wr_ok && wr_hit[1];
   assign both_permit = o_hardware_permit_status && o_software_write_permit;

   // ------------------------------------------------------------
   // permit bits and fault flag
   // ------------------------------------------------------------

   // hardware permit mirrors the inverted protect pin
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_hardware_permit_status <= 1'b0;
      end else begin
         // pin low gives 1, pin high gives 0
         o_hardware_permit_status <= ~i_protect_pin;
      end
   end

   // software write permit, settable only under hardware permit
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_software_write_permit <= 1'b0;
      end else if (i_standby) begin
         // standby entry clears the lower register, save the pin-driven bit 7
         o_software_write_permit <= 1'b0;
      end else if (wr_lower && o_hardware_permit_status) begin
         // old value gates the mode bits, so a joint write sets only this bit
         o_software_write_permit <= w_byte[`FMC_BIT_SW_PERMIT];
      end
   end

   // fault flag: sticky, cleared by the reset pin alone
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_flash_fault_flag <= 1'b0;
      end else if (i_fault_detect) begin
         // no software clear exists, so an event is never lost
         o_flash_fault_flag <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // mode fields of both halves
   // ------------------------------------------------------------

   // write strobe per half, index 0 lower, 1 upper
   wire [1:0] half_wr;
   // synchronous clear per half
   wire [1:0] half_clr;
   // both mode fields side by side
   wire [11:0] half_bits;

   assign half_wr = {wr_upper, wr_lower};
   // lower clears on standby only
   assign half_clr[0] = i_standby;
   // upper also clears whenever a permit is missing
   assign half_clr[1] = i_standby || !both_permit;

   // one mode field instance per half of the array
   genvar h;
   generate
      for (h = 0; h < 2; h = h + 1) begin : g_half
         fmc_half u_half (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_clear(half_clr[h]),
            .i_wr_en(half_wr[h]),
            .i_wr_data(w_byte[5:0]),
            .i_permit(both_permit),
            .i_fault(o_flash_fault_flag),
            .o_bits(half_bits[h*6+5:h*6])
         );
      end
   endgenerate

   // mode fields leave the block straight from their flops
   assign o_mode_lower = half_bits[5:0];
   assign o_mode_upper = half_bits[11:6];

   // ------------------------------------------------------------
   // read values and read side of the bus slave
   // ------------------------------------------------------------

   // lower register as software sees it
   reg [7:0] rd_lower;
   // upper register as software sees it
   reg [7:0] rd_upper;
   // decoded target of the read address
   wire [1:0] rd_hit;

   assign rd_hit = fmc_decode(i_s_axi_araddr);

   // compose read values, disabled flash gives fixed values
   always @* begin
      rd_lower = `FMC_LOWER_DISABLED;
      rd_upper = `FMC_UPPER_DISABLED;
      if (i_flash_enabled) begin
         rd_lower = {o_hardware_permit_status, o_software_write_permit, o_mode_lower};
         // bit 6 is reserved and reads zero
         rd_upper = {o_flash_fault_flag, 1'b0, o_mode_upper};
      end
   end

   // one read at a time, data at the same edge that takes the address
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_s_axi_arready <= 1'b1;
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata <= 32'h0000_0000;
         o_s_axi_rresp <= `FMC_RESP_OKAY;
      end else if (i_s_axi_arvalid && o_s_axi_arready) begin
         o_s_axi_arready <= 1'b0;
         o_s_axi_rvalid <= 1'b1;
         // upper byte lanes always read zero
         if (rd_hit[0]) begin
            o_s_axi_rdata <= {24'h00_0000, rd_lower};
            o_s_axi_rresp <= `FMC_RESP_OKAY;
         end else if (rd_hit[1]) begin
            o_s_axi_rdata <= {24'h00_0000, rd_upper};
            o_s_axi_rresp <= `FMC_RESP_OKAY;
         end else begin
            // unmapped address reads zero with slave error
            o_s_axi_rdata <= 32'h0000_0000;
            o_s_axi_rresp <= `FMC_RESP_SLVERR;
         end
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
         // answer taken, accept the next address
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_arready <= 1'b1;
      end
   end

endmodule

// File: logic/fmc_dummy_placeholder_removed.v
// holds no logic: the block is fmc_top with its fmc_half mode fields

// File: bench/fmcr_sva.sv
// assertion checker for the flash mode control registers
`timescale 1ns/1ps

module fmcr_sva (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_protect_pin,
   input wire i_standby,
   input wire i_fault_detect,
   input wire o_hardware_permit_status,
   input wire o_software_write_permit,
   input wire o_flash_fault_flag,
   input wire [5:0] o_mode_lower,
   input wire [5:0] o_mode_upper
);
   // one clock domain, reset disables every check
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // both permits, as the gating sees them
   wire both = o_hardware_permit_status && o_software_write_permit;

   a_permit_lag: assert property ($past(i_rst_n) |->
      o_hardware_permit_status == !$past(i_protect_pin)) else $error("permit lag");
   a_sw_needs_hw: assert property ($rose(o_software_write_permit) |->
      $past(o_hardware_permit_status)) else $error("sw permit set");
   a_lower_setup: assert property ((o_mode_lower[5:2] & ~$past(o_mode_lower[5:2])) != 4'h0
      |-> $past(both)) else $error("lower setup gate");
   a_upper_setup: assert property ((o_mode_upper[5:2] & ~$past(o_mode_upper[5:2])) != 4'h0
      |-> $past(both)) else $error("upper setup gate");
   a_lower_erase_go: assert property ($rose(o_mode_lower[1]) |->
      $past(both && o_mode_lower[5] && !o_flash_fault_flag)) else $error("erase go gate");
   a_upper_prog_go: assert property ($rose(o_mode_upper[0]) |->
      $past(both && o_mode_upper[4] && !o_flash_fault_flag)) else $error("prog go gate");
   a_upper_clears: assert property (!both |=> o_mode_upper == 6'h00)
      else $error("upper kept");
   a_standby_clears: assert property (i_standby |=> !o_software_write_permit &&
      o_mode_lower == 6'h00 && o_mode_upper == 6'h00) else $error("standby kept");
   a_fault_sets: assert property (i_fault_detect |=> o_flash_fault_flag)
      else $error("fault not set");
   a_fault_sticky: assert property (o_flash_fault_flag |=> o_flash_fault_flag)
      else $error("fault lost");
   a_fault_blocks: assert property (o_flash_fault_flag && $past(o_flash_fault_flag) |->
      {o_mode_lower[1:0], o_mode_upper[1:0]} == 4'h0) else $error("go under fault");
   // main scenarios reached
   c_prog_go: cover property ($rose(o_mode_lower[0]));
   c_erase_go: cover property ($rose(o_mode_upper[1]));
   c_fault: cover property ($rose(o_flash_fault_flag));
endmodule

bind fmc_top fmcr_sva i_fmcr_sva (.*);

// File: bench/flash_mode_control_regs_tb_top.sv
// self-checking bench for the flash mode control registers
`timescale 1ns/1ps
`include "fmc_consts.vh"

module flash_mode_control_regs_tb_top;
   // side inputs
   logic i_clk = 0, i_rst_n = 0, i_protect_pin = 0, i_standby = 0;
   logic i_flash_enabled = 1, i_fault_detect = 0;
   // bus master side
   logic [3:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0, i_s_axi_wstrb = 0;
   logic [31:0] i_s_axi_wdata = 0;
   logic i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
   logic i_s_axi_arvalid = 0, i_s_axi_rready = 0;
   // block outputs
   wire o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
   wire [1:0] o_s_axi_bresp, o_s_axi_rresp;
   wire [31:0] o_s_axi_rdata;
   wire o_hardware_permit_status, o_software_write_permit, o_flash_fault_flag;
   wire [5:0] o_mode_lower, o_mode_upper;
   // expectations waiting for the monitor
   logic [31:0] rd_q[$];
   logic [1:0] br_q[$];
   logic [1:0] rr_q[$];
   int mismatches = 0, cmp_count = 0, seed = 32'hd86f_fb92, i;
   logic [31:0] rnd;
   logic [5:0] ex;
   // mode fields written in turn to each half
   logic [5:0] wm[12] = '{6'h01, 6'h02, 6'h10, 6'h11, 6'h00, 6'h20, 6'h22, 6'h00,
      6'h08, 6'h00, 6'h04, 6'h00};

   fmc_top i_fmc_top (.*);

   // 200 MHz clock
   always #2.5 i_clk = ~i_clk;

   // compare one value
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // verdict and end of run
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // a wait ran out
   task automatic fail_out;
      mismatches++;
      complete_run();
   endtask

   // each answer is checked against the oldest note
   always @(posedge i_clk) begin
      if (o_s_axi_rvalid && i_s_axi_rready) begin
         check("rdata", o_s_axi_rdata, rd_q.pop_front());
         check("rresp", {30'h0, o_s_axi_rresp}, {30'h0, rr_q.pop_front()});
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
         check("bresp", {30'h0, o_s_axi_bresp}, {30'h0, br_q.pop_front()});
      end
   end

   // one bus write; the upper data bits are random and must be ignored
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r,
         input logic [3:0] s = 4'h1);
      int n;
      br_q.push_back(r);
      rnd = $random(seed);
      @(posedge i_clk);
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= {rnd[31:8], d};
      i_s_axi_wstrb <= s;
      i_s_axi_awvalid <= 1;
      i_s_axi_wvalid <= 1;
      i_s_axi_bready <= 1;
      for (n = 0; n < 40; n++) begin
         @(posedge i_clk);
         if (o_s_axi_awready && i_s_axi_awvalid) i_s_axi_awvalid <= 0;
         if (o_s_axi_wready && i_s_axi_wvalid) i_s_axi_wvalid <= 0;
         if (o_s_axi_bvalid) break;
      end
      i_s_axi_bready <= 0;
      if (n == 40) fail_out();
   endtask

   // one bus read with the expected byte
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      int n;
      rd_q.push_back({24'h00_0000, e});
      rr_q.push_back((a == `FMC_OFS_LOWER || a == `FMC_OFS_UPPER) ?
         `FMC_RESP_OKAY : `FMC_RESP_SLVERR);
      @(posedge i_clk);
      i_s_axi_araddr <= a;
      i_s_axi_arvalid <= 1;
      i_s_axi_rready <= 1;
      for (n = 0; n < 40; n++) begin
         @(posedge i_clk);
         if (o_s_axi_arready && i_s_axi_arvalid) i_s_axi_arvalid <= 0;
         if (o_s_axi_rvalid) break;
      end
      i_s_axi_rready <= 0;
      if (n == 40) fail_out();
   endtask

   // write then read back
   task automatic wc(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
      wr(a, d, `FMC_RESP_OKAY);
      rd(a, e);
   endtask

   // hold reset for five cycles
   task automatic do_reset;
      @(posedge i_clk);
      i_rst_n <= 0;
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1;
   endtask

   // pulse a side input for one cycle
   task automatic pulse(input int which);
      @(posedge i_clk);
      if (which == 0) i_standby <= 1;
      else i_fault_detect <= 1;
      @(posedge i_clk);
      i_standby <= 0;
      i_fault_detect <= 0;
   endtask

   // main sequence
   initial begin
      do_reset();
      rd(`FMC_OFS_LOWER, 8'h80);
      rd(`FMC_OFS_UPPER, 8'h00);
      wc(`FMC_OFS_LOWER, 8'h10, 8'h80);
      wc(`FMC_OFS_UPPER, 8'h10, 8'h00);
      wc(`FMC_OFS_LOWER, 8'h40, 8'hc0);
      $display("test reset and gating done");
      // go without setup refused, then setup, go, verify in each half
      for (i = 0; i < 12; i++) begin
         ex = (i < 2) ? 6'h00 : wm[i];
         wc(`FMC_OFS_LOWER, {rnd[7], 1'b1, wm[i]}, {2'b11, ex});
         wc(`FMC_OFS_UPPER, {rnd[7:6], wm[i]}, {2'b00, ex});
      end
      $display("test mode sequences done");
      wr(4'h8, 8'h00, `FMC_RESP_SLVERR);
      rd(4'hc, 8'h00);
      wr(`FMC_OFS_LOWER, 8'h00, `FMC_RESP_OKAY, 4'h0);
      wc(`FMC_OFS_UPPER, 8'h10, 8'h10);
      @(posedge i_clk);
      i_flash_enabled <= 0;
      rd(`FMC_OFS_LOWER, 8'h80);
      wc(`FMC_OFS_UPPER, 8'h00, 8'h00);
      wr(`FMC_OFS_LOWER, 8'h00, `FMC_RESP_OKAY);
      @(posedge i_clk);
      i_flash_enabled <= 1;
      rd(`FMC_OFS_LOWER, 8'hc0);
      rd(`FMC_OFS_UPPER, 8'h10);
      $display("test disabled flash done");
      @(posedge i_clk);
      i_protect_pin <= 1;
      // the permit flop lags the pin, the upper clear lags the permit
      @(posedge i_clk);
      rd(`FMC_OFS_UPPER, 8'h00);
      wc(`FMC_OFS_LOWER, 8'h48, 8'h40);
      @(posedge i_clk);
      i_protect_pin <= 0;
      wc(`FMC_OFS_LOWER, 8'h50, 8'hd0);
      pulse(0);
      rd(`FMC_OFS_LOWER, 8'h80);
      $display("test protect and standby done");
      wc(`FMC_OFS_LOWER, 8'h40, 8'hc0);
      wc(`FMC_OFS_LOWER, 8'h50, 8'hd0);
      wc(`FMC_OFS_LOWER, 8'h51, 8'hd1);
      pulse(1);
      rd(`FMC_OFS_LOWER, 8'hd0);
      rd(`FMC_OFS_UPPER, 8'h80);
      wc(`FMC_OFS_LOWER, 8'h51, 8'hd0);
      pulse(0);
      rd(`FMC_OFS_UPPER, 8'h80);
      i_protect_pin <= 1;
      do_reset();
      rd(`FMC_OFS_LOWER, 8'h00);
      rd(`FMC_OFS_UPPER, 8'h00);
      $display("test fault and second reset done");
      complete_run();
   end
endmodule
